/* rtl/pme_pkg.sv */
package pme_pkg;
    localparam int PME_CLK_HZ = 25_000_000;
    // Pulse burst on the mode-select pin.
    localparam logic [3:0] PME_PULSE_MAX = 4'hb;
    localparam logic [3:0] PME_PULSE_SAT = 4'hc;
    localparam logic [3:0] PME_PULSES_UART_XTAL = 4'h0;
    localparam logic [3:0] PME_PULSES_UART_EXT = 4'h3;
    localparam logic [3:0] PME_PULSES_CSI = 4'h8;
    // Quiet high time that closes a pulse burst.
    localparam int PME_BURST_IDLE_US = 1000;
    localparam int PME_BURST_IDLE_CYC = PME_BURST_IDLE_US * (PME_CLK_HZ / 1_000_000);
    // Clocked serial channel transfer clock limits.
    localparam int PME_SCLK_MAX_HZ = 2_500_000;
    localparam int PME_SCLK_MIN_HZ = 2_400;
    localparam int PME_SCLK_MIN_HALF_CYC =
        (PME_CLK_HZ + 2 * PME_SCLK_MAX_HZ - 1) / (2 * PME_SCLK_MAX_HZ);
    localparam int PME_SCLK_MAX_HALF_CYC = PME_CLK_HZ / (2 * PME_SCLK_MIN_HZ);
    // Asynchronous channel fixed rate.
    localparam int PME_UART_BPS = 115_200;
    localparam logic [15:0] PME_UART_BIT_CYC = 16'(PME_CLK_HZ / PME_UART_BPS);
    localparam logic [15:0] PME_UART_TOL_CYC = 16'h0008;
    localparam int PME_RESET_CMD_LOW_BITS = 1;
    localparam logic [15:0] PME_CNT_SAT = 16'hffff;

    typedef enum logic [6:0] {
        ST_STRAP = 7'h01,
        ST_NORMAL = 7'h02,
        ST_COUNT = 7'h04,
        ST_UART_SYNC = 7'h08,
        ST_UART_RUN = 7'h10,
        ST_CSI_RUN = 7'h20,
        ST_ERROR = 7'h40
    } pme_state_type;

    typedef enum logic [3:0] {
        COMM_NONE = 4'h1,
        COMM_UART_XTAL = 4'h2,
        COMM_UART_EXT = 4'h4,
        COMM_CSI = 4'h8
    } pme_comm_type;
endpackage

/* rtl/pme_sel_if.sv */
`timescale 1ns/1ps
interface pme_sel_if;
    logic count_en;
    logic [3:0] pulse_count;
    logic burst_done;
    logic meter_uart;
    logic meter_csi;
    logic [15:0] bit_cycles;
    logic baud_locked;
    logic rate_err;
    modport counter (input count_en, output pulse_count, output burst_done);
    modport meter (input meter_uart, input meter_csi, output bit_cycles, output baud_locked,
        output rate_err);
    modport ctrl (output count_en, output meter_uart, output meter_csi, input pulse_count,
        input burst_done, input bit_cycles, input baud_locked, input rate_err);
endinterface

/* rtl/pme_pulse_counter.sv */
`timescale 1ns/1ps
module pme_pulse_counter
    import pme_pkg::*;
#(
    parameter int IDLE_CYC = PME_BURST_IDLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mode_pin,
    pme_sel_if.counter sel
);
    typedef struct packed {
        logic prev;
        logic [3:0] cnt;
        logic [23:0] idle;
        logic done;
    } pme_cnt_state_type;

    pme_cnt_state_type st_q;
    pme_cnt_state_type st_d;

    always_comb begin
        st_d = st_q;
        st_d.prev = mode_pin;
        if (!sel.count_en) begin
            st_d.cnt = 4'h0;
            st_d.idle = 24'h000000;
            st_d.done = 1'b0;
        end else if (!st_q.done) begin
            if (!mode_pin) begin
                st_d.idle = 24'h000000;
            end else if (!st_q.prev) begin
                // A pulse is a low phase ended by the return to high.
                // Counting saturates one past the legal maximum so overruns stay visible.
                st_d.idle = 24'h000000;
                if (st_q.cnt != PME_PULSE_SAT) begin
                    st_d.cnt = st_q.cnt + 4'h1;
                end
            end else if (st_q.idle < 24'(IDLE_CYC - 1)) begin
                st_d.idle = st_q.idle + 24'h000001;
            end else begin
                st_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '{prev: 1'b1, cnt: 4'h0, idle: 24'h000000, done: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign sel.pulse_count = st_q.cnt;
    assign sel.burst_done = st_q.done;
endmodule

/* rtl/pme_rate_meter.sv */
`timescale 1ns/1ps
module pme_rate_meter
    import pme_pkg::*;
#(
    parameter int SCLK_MAX_HALF = PME_SCLK_MAX_HALF_CYC,
    parameter int RESET_CMD_LOW_BITS = PME_RESET_CMD_LOW_BITS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_pin,
    input wire logic sclk_pin,
    pme_sel_if.meter sel
);
    typedef struct packed {
        logic prev_rx;
        logic prev_sclk;
        logic meas_on;
        logic [15:0] width;
        logic locked;
        logic [15:0] bits;
        logic err;
        logic [15:0] phase;
    } pme_meter_state_type;

    pme_meter_state_type st_q;
    pme_meter_state_type st_d;
    logic [15:0] bit_est;

    assign bit_est = 16'(st_q.width / 16'(RESET_CMD_LOW_BITS));

    always_comb begin
        st_d = st_q;
        st_d.prev_rx = rx_pin;
        st_d.prev_sclk = sclk_pin;
        if (sel.meter_uart) begin
            // The first low run after entry is the start of the reset command.
            if (!st_q.locked && !st_q.meas_on && st_q.prev_rx && !rx_pin) begin
                st_d.meas_on = 1'b1;
                st_d.width = 16'h0001;
            end else if (st_q.meas_on && !rx_pin) begin
                if (st_q.width != PME_CNT_SAT) begin
                    st_d.width = st_q.width + 16'h0001;
                end
            end else if (st_q.meas_on && rx_pin) begin
                st_d.meas_on = 1'b0;
                st_d.locked = 1'b1;
                st_d.bits = bit_est;
                if (bit_est < PME_UART_BIT_CYC - PME_UART_TOL_CYC ||
                    bit_est > PME_UART_BIT_CYC + PME_UART_TOL_CYC) begin
                    st_d.err = 1'b1;
                end
            end
        end else if (sel.meter_csi) begin
            if (st_q.prev_sclk != sclk_pin) begin
                if (st_q.phase < 16'(PME_SCLK_MIN_HALF_CYC)) begin
                    st_d.err = 1'b1;
                end
                st_d.phase = 16'h0001;
            end else begin
                if (st_q.phase != PME_CNT_SAT) begin
                    st_d.phase = st_q.phase + 16'h0001;
                end
                // The clock idles high between bytes, so only a long low phase is too slow.
                if (!sclk_pin && st_q.phase > 16'(SCLK_MAX_HALF)) begin
                    st_d.err = 1'b1;
                end
            end
        end else begin
            st_d.phase = PME_CNT_SAT;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '{prev_rx: 1'b1, prev_sclk: 1'b1, meas_on: 1'b0, width: 16'h0000,
                locked: 1'b0, bits: 16'h0000, err: 1'b0, phase: 16'hffff};
        end else begin
            st_q <= st_d;
        end
    end

    assign sel.bit_cycles = st_q.bits;
    assign sel.baud_locked = st_q.locked;
    assign sel.rate_err = st_q.err;
endmodule

/* rtl/pme_mode_entry.sv */
// What this block does
// - In programming mode, all non-programming pins stay in their post-reset state.
// - Mode-select pin low at reset release selects normal operation.
// - Mode-select pin high at reset release enters programming mode.
// - Programmer then sends up to 11 pulses; device counts them.
// - Zero pulses: UART on crystal; three: UART external clock; eight: clocked serial.
// - Clocked serial mode runs only on internal fast oscillator, clock up to 2.5 MHz.
// - UART mode runs only on crystal or external clock, never internal oscillator.
// - UART receive bit timing is measured from the programmer's reset command.
// - Clocked serial uses out, in and clock pins; UART uses transmit and receive.
// - Programmer starts every exchange; device answers each command.
// - Clocked serial accepts 2.4 kHz to 2.5 MHz; UART fixed at 115200 bps.
`timescale 1ns/1ps
module pme_mode_entry
    import pme_pkg::*;
#(
    parameter int BURST_IDLE_CYCLES = PME_BURST_IDLE_CYC,
    parameter int SCLK_MAX_HALF_CYCLES = PME_SCLK_MAX_HALF_CYC,
    parameter int RESET_CMD_LOW_BITS = PME_RESET_CMD_LOW_BITS
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic MODE_SELECT_PIN,
    input wire logic ASYNC_RECEIVE_PIN,
    input wire logic CLOCKED_SERIAL_SCLK,
    output logic PROG_MODE,
    output logic NORMAL_MODE,
    output logic HOLD_PORTS_AT_RESET_STATE,
    output pme_pkg::pme_comm_type COMM_MODE,
    output logic CLK_SEL_CRYSTAL,
    output logic CLK_SEL_EXTERNAL,
    output logic CLK_SEL_INT_FAST_OSC,
    output logic ASYNC_CHANNEL_EN,
    output logic CLOCKED_CHANNEL_EN,
    output logic ASYNC_TRANSMIT_PIN_OE_N,
    output logic CLOCKED_SERIAL_OUT_OE_N,
    output logic LINK_READY,
    output logic [15:0] BAUD_BIT_CYCLES,
    output logic MODE_ERROR,
    output logic RATE_ERROR
);
    import pme_pkg::*;

    typedef struct packed {
        pme_state_type state;
        logic prog;
        logic normal;
        logic hold;
        pme_comm_type comm;
        logic clk_xtal;
        logic clk_ext;
        logic clk_int;
        logic async_en;
        logic csi_en;
        logic tx_oe_n;
        logic so_oe_n;
        logic ready;
        logic [15:0] baud;
        logic mode_err;
        logic rate_err;
    } pme_top_state_type;

    localparam pme_top_state_type PME_TOP_RESET = '{
        state: ST_STRAP, prog: 1'b0, normal: 1'b0, hold: 1'b0, comm: COMM_NONE,
        clk_xtal: 1'b0, clk_ext: 1'b0, clk_int: 1'b0, async_en: 1'b0, csi_en: 1'b0,
        tx_oe_n: 1'b1, so_oe_n: 1'b1, ready: 1'b0, baud: 16'h0000, mode_err: 1'b0,
        rate_err: 1'b0};

    pme_top_state_type st_q;
    pme_top_state_type st_d;

    pme_sel_if sel ();

    function automatic pme_comm_type decode_pulses(input logic [3:0] n);
        if (n == PME_PULSES_UART_XTAL) begin
            decode_pulses = COMM_UART_XTAL;
        end else if (n == PME_PULSES_UART_EXT) begin
            decode_pulses = COMM_UART_EXT;
        end else if (n == PME_PULSES_CSI) begin
            decode_pulses = COMM_CSI;
        end else begin
            decode_pulses = COMM_NONE;
        end
    endfunction

    pme_pulse_counter #(
        .IDLE_CYC(BURST_IDLE_CYCLES)
    ) u_counter (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .mode_pin(MODE_SELECT_PIN),
        .sel(sel.counter)
    );

    pme_rate_meter #(
        .SCLK_MAX_HALF(SCLK_MAX_HALF_CYCLES),
        .RESET_CMD_LOW_BITS(RESET_CMD_LOW_BITS)
    ) u_meter (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .rx_pin(ASYNC_RECEIVE_PIN),
        .sclk_pin(CLOCKED_SERIAL_SCLK),
        .sel(sel.meter)
    );

    assign sel.count_en = (st_q.state == ST_COUNT);
    assign sel.meter_uart = st_q.async_en;
    assign sel.meter_csi = st_q.csi_en;

    always_comb begin
        pme_comm_type comm;
        comm = decode_pulses(sel.pulse_count);
        st_d = st_q;
        case (st_q.state)
            ST_STRAP: begin
                // The strap is caught on the first clock after reset lets go.
                if (MODE_SELECT_PIN) begin
                    st_d.state = ST_COUNT;
                    st_d.prog = 1'b1;
                    st_d.hold = 1'b1;
                end else begin
                    st_d.state = ST_NORMAL;
                    st_d.normal = 1'b1;
                end
            end
            ST_NORMAL: begin
                st_d.state = ST_NORMAL;
            end
            ST_COUNT: begin
                if (sel.burst_done) begin
                    st_d.comm = comm;
                    if (sel.pulse_count > PME_PULSE_MAX || comm == COMM_NONE) begin
                        st_d.state = ST_ERROR;
                        st_d.mode_err = 1'b1;
                    end else if (comm == COMM_CSI) begin
                        st_d.state = ST_CSI_RUN;
                        st_d.clk_int = 1'b1;
                        st_d.csi_en = 1'b1;
                        st_d.so_oe_n = 1'b0;
                        // No rate lock is needed: the programmer supplies the clock.
                        st_d.ready = 1'b1;
                    end else begin
                        st_d.state = ST_UART_SYNC;
                        st_d.clk_xtal = (comm == COMM_UART_XTAL);
                        st_d.clk_ext = (comm == COMM_UART_EXT);
                        st_d.async_en = 1'b1;
                        st_d.tx_oe_n = 1'b0;
                    end
                end
            end
            ST_UART_SYNC: begin
                if (sel.baud_locked) begin
                    if (sel.rate_err) begin
                        st_d.state = ST_ERROR;
                        st_d.rate_err = 1'b1;
                    end else begin
                        st_d.state = ST_UART_RUN;
                        st_d.baud = sel.bit_cycles;
                        st_d.ready = 1'b1;
                    end
                end
            end
            ST_UART_RUN: begin
                st_d.state = ST_UART_RUN;
            end
            ST_CSI_RUN: begin
                // A rate fault is reported but the channel keeps running.
                if (sel.rate_err) begin
                    st_d.rate_err = 1'b1;
                end
            end
            ST_ERROR: begin
                // Only a fresh reset leaves the fault state, so the outputs stay parked.
                st_d.ready = 1'b0;
                st_d.tx_oe_n = 1'b1;
                st_d.so_oe_n = 1'b1;
                st_d.async_en = 1'b0;
                st_d.csi_en = 1'b0;
            end
            default: begin
                st_d = PME_TOP_RESET;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_q <= PME_TOP_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign PROG_MODE = st_q.prog;
    assign NORMAL_MODE = st_q.normal;
    assign HOLD_PORTS_AT_RESET_STATE = st_q.hold;
    assign COMM_MODE = st_q.comm;
    assign CLK_SEL_CRYSTAL = st_q.clk_xtal;
    assign CLK_SEL_EXTERNAL = st_q.clk_ext;
    assign CLK_SEL_INT_FAST_OSC = st_q.clk_int;
    assign ASYNC_CHANNEL_EN = st_q.async_en;
    assign CLOCKED_CHANNEL_EN = st_q.csi_en;
    assign ASYNC_TRANSMIT_PIN_OE_N = st_q.tx_oe_n;
    assign CLOCKED_SERIAL_OUT_OE_N = st_q.so_oe_n;
    assign LINK_READY = st_q.ready;
    assign BAUD_BIT_CYCLES = st_q.baud;
    assign MODE_ERROR = st_q.mode_err;
    assign RATE_ERROR = st_q.rate_err;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST);

    property p_strap_normal;
        (st_q.state == ST_STRAP && !MODE_SELECT_PIN) |=> NORMAL_MODE && !PROG_MODE;
    endproperty
    a_strap_normal: assert property (p_strap_normal) else $error("low strap not normal");

    property p_strap_prog;
        (st_q.state == ST_STRAP && MODE_SELECT_PIN) |=> PROG_MODE && !NORMAL_MODE;
    endproperty
    a_strap_prog: assert property (p_strap_prog) else $error("high strap not prog");

    property p_hold_ports;
        PROG_MODE |-> HOLD_PORTS_AT_RESET_STATE;
    endproperty
    a_hold_ports: assert property (p_hold_ports) else $error("ports not held");

    property p_overrun;
        (st_q.state == ST_COUNT && sel.burst_done && sel.pulse_count > 4'hb)
            |=> MODE_ERROR && !LINK_READY;
    endproperty
    a_overrun: assert property (p_overrun) else $error("pulse overrun missed");

    property p_decode_three;
        (st_q.state == ST_COUNT && sel.burst_done && sel.pulse_count == 4'h3)
            |=> COMM_MODE == COMM_UART_EXT && CLK_SEL_EXTERNAL && ASYNC_CHANNEL_EN;
    endproperty
    a_decode_three: assert property (p_decode_three) else $error("three pulses misdecoded");

    property p_decode_eight;
        (st_q.state == ST_COUNT && sel.burst_done && sel.pulse_count == 4'h8)
            |=> COMM_MODE == COMM_CSI ##0 LINK_READY [*2];
    endproperty
    a_decode_eight: assert property (p_decode_eight) else $error("eight pulses misdecoded");

    property p_csi_clock;
        CLOCKED_CHANNEL_EN |-> CLK_SEL_INT_FAST_OSC && !CLK_SEL_CRYSTAL && !CLK_SEL_EXTERNAL;
    endproperty
    a_csi_clock: assert property (p_csi_clock) else $error("clocked serial wrong clock");

    property p_uart_clock;
        ASYNC_CHANNEL_EN |-> !CLK_SEL_INT_FAST_OSC && (CLK_SEL_CRYSTAL != CLK_SEL_EXTERNAL);
    endproperty
    a_uart_clock: assert property (p_uart_clock) else $error("uart wrong clock");

    property p_baud_taken;
        (st_q.state == ST_UART_SYNC && sel.baud_locked && !sel.rate_err)
            |=> LINK_READY && BAUD_BIT_CYCLES == $past(sel.bit_cycles);
    endproperty
    a_baud_taken: assert property (p_baud_taken) else $error("baud not taken");

    property p_pin_use;
        ASYNC_CHANNEL_EN |-> CLOCKED_SERIAL_OUT_OE_N && !ASYNC_TRANSMIT_PIN_OE_N;
    endproperty
    a_pin_use: assert property (p_pin_use) else $error("wrong pins driven");

    property p_ready_prog;
        LINK_READY |-> PROG_MODE && !MODE_ERROR;
    endproperty
    a_ready_prog: assert property (p_ready_prog) else $error("ready outside prog");

    property p_rate_flag;
        (CLOCKED_CHANNEL_EN && sel.rate_err) |=> RATE_ERROR;
    endproperty
    a_rate_flag: assert property (p_rate_flag) else $error("rate fault lost");

    property p_decode_zero;
        (st_q.state == ST_COUNT && sel.burst_done && sel.pulse_count == PME_PULSES_UART_XTAL)
            |=> COMM_MODE == COMM_UART_XTAL && CLK_SEL_CRYSTAL && ASYNC_CHANNEL_EN && !LINK_READY;
    endproperty
    a_decode_zero: assert property (p_decode_zero) else $error("zero pulses misdecoded");

    // Once parked, nothing may drive a programming pin until the next reset.
    property p_error_park;
        (st_q.state == ST_ERROR) |=> !LINK_READY && !ASYNC_CHANNEL_EN && !CLOCKED_CHANNEL_EN &&
            ASYNC_TRANSMIT_PIN_OE_N && CLOCKED_SERIAL_OUT_OE_N;
    endproperty
    a_error_park: assert property (p_error_park) else $error("fault state not parked");

    property p_normal_quiet;
        NORMAL_MODE |-> !PROG_MODE && !LINK_READY && !ASYNC_CHANNEL_EN && !CLOCKED_CHANNEL_EN;
    endproperty
    a_normal_quiet: assert property (p_normal_quiet) else $error("normal mode not quiet");

    property p_sync_wait;
        (st_q.state == ST_UART_SYNC && !sel.baud_locked) |=> !LINK_READY;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("ready before rate lock");

    c_normal: cover property (NORMAL_MODE);
    c_uart_xtal: cover property (LINK_READY && CLK_SEL_CRYSTAL);
    c_uart_ext: cover property (LINK_READY && CLK_SEL_EXTERNAL);
    c_csi: cover property (LINK_READY && CLOCKED_CHANNEL_EN);
    c_rate_fault: cover property (RATE_ERROR && CLOCKED_CHANNEL_EN);
endmodule

/* tb/pme_prog_model.sv */
`timescale 1ns/1ps
module pme_prog_model (
    input wire logic clk,
    output logic rst,
    output logic mode_pin,
    output logic rx,
    output logic sclk
);
    initial begin
        rst = 1'b1;
        mode_pin = 1'b0;
        rx = 1'b1;
        sclk = 1'b1;
    end

    // Only this model drives the reset, so no second reset source can disturb a session.
    task automatic enter(input logic strap, input int pulses);
        @(negedge clk);
        rst = 1'b1;
        rx = 1'b1;
        sclk = 1'b1;
        mode_pin = strap;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < pulses; i++) begin
            mode_pin = 1'b0;
            repeat (2) @(negedge clk);
            mode_pin = 1'b1;
            repeat (2) @(negedge clk);
        end
    endtask

    task automatic reset_cmd(input int width);
        rx = 1'b0;
        repeat (width) @(negedge clk);
        rx = 1'b1;
    endtask

    // The transfer clock stands high between frames; an even edge count ends it there.
    task automatic sclk_run(input int half, input int edges);
        repeat (edges) begin
            repeat (half) @(negedge clk);
            sclk = ~sclk;
        end
        // An odd edge count leaves the clock low; one more phase returns it to idle.
        if (edges % 2 != 0) begin
            repeat (half) @(negedge clk);
            sclk = 1'b1;
        end
    endtask
endmodule

/* tb/programming_mode_entry_select_test.sv */
`timescale 1ns/1ps
module programming_mode_entry_select_test;
    import pme_pkg::*;
    localparam int IDLE = 20;
    localparam int SLOW = 50;
    logic clk = 1'b0;
    logic rst, mode_pin, rx, sclk;
    logic prog_mode, normal_mode, hold, xtal, ext, fast, async_en, clocked_en;
    logic tx_oe_n, so_oe_n, link_ready, mode_err, rate_err;
    pme_comm_type comm_mode;
    logic [15:0] baud;
    logic [31:0] lfsr = 32'h47ec;
    int counts[$] = '{0, 3, 8, 11, 12};
    int mismatches = 0;
    int tests_run = 0;

    always #20 clk = ~clk;

    pme_prog_model i_prog (.clk(clk), .rst(rst), .mode_pin(mode_pin), .rx(rx), .sclk(sclk));

    pme_mode_entry #(
        .BURST_IDLE_CYCLES(IDLE),
        .SCLK_MAX_HALF_CYCLES(SLOW),
        .RESET_CMD_LOW_BITS(1)
    ) i_dut (
        .CORE_CLK(clk),
        .SYS_RST(rst),
        .MODE_SELECT_PIN(mode_pin),
        .ASYNC_RECEIVE_PIN(rx),
        .CLOCKED_SERIAL_SCLK(sclk),
        .PROG_MODE(prog_mode),
        .NORMAL_MODE(normal_mode),
        .HOLD_PORTS_AT_RESET_STATE(hold),
        .COMM_MODE(comm_mode),
        .CLK_SEL_CRYSTAL(xtal),
        .CLK_SEL_EXTERNAL(ext),
        .CLK_SEL_INT_FAST_OSC(fast),
        .ASYNC_CHANNEL_EN(async_en),
        .CLOCKED_CHANNEL_EN(clocked_en),
        .ASYNC_TRANSMIT_PIN_OE_N(tx_oe_n),
        .CLOCKED_SERIAL_OUT_OE_N(so_oe_n),
        .LINK_READY(link_ready),
        .BAUD_BIT_CYCLES(baud),
        .MODE_ERROR(mode_err),
        .RATE_ERROR(rate_err)
    );

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        check16(what, {15'h0, exp}, {15'h0, got});
    endtask

    function automatic int exp_comm(input int n);
        return (n == 0) ? 2 : (n == 3) ? 4 : (n == 8) ? 8 : 0;
    endfunction

    task automatic check_mode(input int n);
        int c;
        logic ok;
        c = exp_comm(n);
        ok = (c != 0);
        check1("PROG_MODE", 1'b1, prog_mode);
        check1("NORMAL_MODE", 1'b0, normal_mode);
        check1("HOLD_PORTS", 1'b1, hold);
        check1("MODE_ERROR", !ok, mode_err);
        check1("ASYNC_EN", ok && c != 8, async_en);
        check1("CLOCKED_EN", c == 8, clocked_en);
        check1("TX_OE_N", !(ok && c != 8), tx_oe_n);
        check1("SO_OE_N", c != 8, so_oe_n);
        check16("COMM_MODE", ok ? 16'(c) : 16'(COMM_NONE), {12'h0, comm_mode});
        if (ok) begin
            check1("CLK_XTAL", c == 2, xtal);
            check1("CLK_EXT", c == 4, ext);
            check1("CLK_FAST", c == 8, fast);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The whole run needs under a thousand cycles; this leaves ample margin.
    initial begin
        repeat (6000) @(posedge clk);
        mismatches++;
        $display("watchdog expired");
        finish_test();
    end

    initial begin
        int w;
        i_prog.enter(1'b0, 0);
        repeat (2) @(negedge clk);
        check1("NORMAL_MODE", 1'b1, normal_mode);
        check1("PROG_MODE", 1'b0, prog_mode);
        check1("HOLD_PORTS", 1'b0, hold);
        $display("test strap low done");
        foreach (counts[k]) begin
            i_prog.enter(1'b1, counts[k]);
            repeat (IDLE + 6) @(negedge clk);
            check_mode(counts[k]);
            if (counts[k] == 0) begin
                lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
                w = 212 + int'(lfsr % 11);
                i_prog.reset_cmd(w);
                repeat (4) @(negedge clk);
                check1("LINK_READY", 1'b1, link_ready);
                check16("BAUD", 16'(w), baud);
                check1("RATE_ERROR", 1'b0, rate_err);
            end else if (counts[k] == 3) begin
                check1("LINK_READY", 1'b0, link_ready);
                i_prog.reset_cmd(100);
                repeat (4) @(negedge clk);
                check1("RATE_ERROR", 1'b1, rate_err);
                check1("LINK_READY", 1'b0, link_ready);
            end else if (counts[k] == 8) begin
                check1("LINK_READY", 1'b1, link_ready);
                i_prog.sclk_run(6, 8);
                repeat (4) @(negedge clk);
                check1("RATE_ERROR", 1'b0, rate_err);
                i_prog.sclk_run(3, 4);
                repeat (4) @(negedge clk);
                check1("RATE_ERROR", 1'b1, rate_err);
                check1("CLOCKED_EN", 1'b1, clocked_en);
            end
            $display("test with %0d pulses done", counts[k]);
        end
        i_prog.enter(1'b1, 8);
        repeat (IDLE + 6) @(negedge clk);
        check1("RATE_ERROR", 1'b0, rate_err);
        i_prog.sclk_run(SLOW + 10, 1);
        repeat (4) @(negedge clk);
        check1("RATE_ERROR", 1'b1, rate_err);
        check1("LINK_READY", 1'b1, link_ready);
        $display("test slow clock done");
        finish_test();
    end
endmodule
